// ==== src/vrar_regs.sv ====
// Version, serial ROM access and transmit retry register bank
`timescale 1ns/100ps
`default_nettype none
`include "vrar_defines.svh"

module vrar_regs #(
	parameter int ROM_AW     = 8,
	parameter int INFO_BYTES = `VRAR_BUS_INFO_BYTES
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [7:0]                 addr,
	input  wire logic [31:0]                wr_data,
	input  wire logic                       wr_en,
	input  wire logic                       rd_en,
	output logic      [31:0]                rd_data_q,
	input  wire logic                       rom_detect,
	output logic                            rom_req_q,
	output logic      [ROM_AW-1:0]          rom_addr_q,
	input  wire logic                       rom_done,
	input  wire logic [7:0]                 rom_data,
	output logic      [8*INFO_BYTES-1:0]    bus_info_q,
	output logic                            bus_info_valid_q,
	input  wire vrar_pkg::vrar_ack_t [2:0]  unit_ack,
	output logic      [2:0]                 unit_retry_q,
	output logic      [2:0]                 unit_give_up_q,
	output logic      [11:0]                unit_last_ack_q
);

	////////////////////////////////////////////////////////////////////////////
	// Register state

	logic                   rom_present_q, rom_present_d;
	logic                   addr_clear_q,  addr_clear_d;
	logic                   read_go_q,     read_go_d;
	logic [7:0]             read_byte_q,   read_byte_d;
	vrar_pkg::vrar_limits_t limits_q,      limits_d;
	logic [31:0]            rd_data_d;
	logic [31:0]            ver_word, rom_word, retry_word;
	logic                   wr_rom, wr_retry;
	logic                   dev_clear_addr, dev_clear_go;

	// Assembled read words; constant fields are wired, not stored
	assign ver_word   = {7'h00, rom_present_q, `VRAR_VER_MAJOR, 8'h00, `VRAR_VER_MINOR};
	assign rom_word   = {addr_clear_q, 5'h00, read_go_q, 1'b0, read_byte_q, 16'h0000};
	assign retry_word = {16'h0000, 4'h0, limits_q};
	assign wr_rom     = wr_en && (addr == `VRAR_OFF_ROM_ACCESS);
	assign wr_retry   = wr_en && (addr == `VRAR_OFF_RETRY);

	// Next register values; a software set beats a same-cycle device clear
	always_comb begin
		rom_present_d = rom_detect;
		addr_clear_d  = (addr_clear_q && !dev_clear_addr) || (wr_rom && wr_data[`VRAR_ROM_CLEAR_BIT]);
		read_go_d     = (read_go_q && !dev_clear_go) || (wr_rom && wr_data[`VRAR_ROM_GO_BIT]);
		limits_d      = wr_retry ? vrar_pkg::vrar_limits_t'(wr_data[11:0]) : limits_q;
		rd_data_d     = 32'h0000_0000;
		if (rd_en) begin
			case (addr)
				`VRAR_OFF_VERSION:    rd_data_d = ver_word;
				`VRAR_OFF_ROM_ACCESS: rd_data_d = rom_word;
				`VRAR_OFF_RETRY:      rd_data_d = retry_word;
				default:              rd_data_d = 32'h0000_0000; // Unmapped reads as zero
			endcase
		end
	end

	// Register stage of the software-visible state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rom_present_q <= 1'b0;
			addr_clear_q  <= 1'b0;
			read_go_q     <= 1'b0;
			limits_q      <= `VRAR_RETRY_RESET;
			rd_data_q     <= 32'h0000_0000;
		end else begin
			rom_present_q <= rom_present_d;
			addr_clear_q  <= addr_clear_d;
			read_go_q     <= read_go_d;
			limits_q      <= limits_d;
			rd_data_q     <= rd_data_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial ROM engine: boot load, address clear and single byte reads

	vrar_pkg::vrar_state_t   state_q, state_d;
	logic                    boot_pend_q, boot_pend_d;
	logic                    req_d;
	logic [ROM_AW-1:0]       raddr_d;
	logic [8*INFO_BYTES-1:0] info_d;
	logic                    info_valid_d;
	logic [7:0]              load_idx_q, load_idx_d;

	// The engine serves one job at a time; software bits wait while booting
	always_comb begin
		state_d        = state_q;
		boot_pend_d    = boot_pend_q;
		req_d          = rom_req_q;
		raddr_d        = rom_addr_q;
		info_d         = bus_info_q;
		info_valid_d   = bus_info_valid_q;
		load_idx_d     = load_idx_q;
		read_byte_d    = read_byte_q;
		dev_clear_addr = 1'b0;
		dev_clear_go   = 1'b0;
		case (state_q)
			vrar_pkg::VRAR_ST_IDLE: begin
				if (boot_pend_q) begin
					boot_pend_d = 1'b0;
					if (rom_detect) begin
						state_d    = vrar_pkg::VRAR_ST_LOAD;
						raddr_d    = '0;
						load_idx_d = 8'h00;
						req_d      = 1'b1;
					end
				end else if (addr_clear_q) begin
					raddr_d        = '0;
					dev_clear_addr = 1'b1;
				end else if (read_go_q) begin
					state_d = vrar_pkg::VRAR_ST_FETCH;
					req_d   = 1'b1;
				end
			end
			vrar_pkg::VRAR_ST_LOAD: begin
				if (rom_done) begin
					info_d[8*load_idx_q[$clog2(INFO_BYTES)-1:0] +: 8] = rom_data;
					raddr_d    = rom_addr_q + 1'b1;
					load_idx_d = load_idx_q + 8'h01;
					if (load_idx_q == 8'(INFO_BYTES - 1)) begin
						state_d      = vrar_pkg::VRAR_ST_IDLE;
						req_d        = 1'b0;
						raddr_d      = '0; // Software starts from byte zero
						info_valid_d = 1'b1;
					end
				end
			end
			vrar_pkg::VRAR_ST_FETCH: begin
				if (rom_done) begin
					read_byte_d  = rom_data;
					raddr_d      = rom_addr_q + 1'b1;
					req_d        = 1'b0;
					dev_clear_go = 1'b1;
					state_d      = vrar_pkg::VRAR_ST_IDLE;
				end
			end
			default: begin
				state_d = vrar_pkg::VRAR_ST_IDLE;
				req_d   = 1'b0;
			end
		endcase
	end

	// Engine registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q          <= vrar_pkg::VRAR_ST_IDLE;
			boot_pend_q      <= 1'b1;
			rom_req_q        <= 1'b0;
			rom_addr_q       <= '0;
			bus_info_q       <= '0;
			bus_info_valid_q <= 1'b0;
			load_idx_q       <= 8'h00;
			read_byte_q      <= `VRAR_ROM_BYTE_RESET;
		end else begin
			state_q          <= state_d;
			boot_pend_q      <= boot_pend_d;
			rom_req_q        <= req_d;
			rom_addr_q       <= raddr_d;
			bus_info_q       <= info_d;
			bus_info_valid_q <= info_valid_d;
			load_idx_q       <= load_idx_d;
			read_byte_q      <= read_byte_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Retry counters, one per transmit unit: 0 request, 1 response, 2 physical

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_unit
			logic [3:0] cnt_q, cnt_d;
			logic [3:0] limit;
			logic       retry_d, give_up_d;
			logic [3:0] last_d;

			assign limit = limits_q[4*gi +: 4];

			// Busy or data-error ack: retry while count remains, else give up
			always_comb begin
				cnt_d     = cnt_q;
				retry_d   = 1'b0;
				give_up_d = 1'b0;
				last_d    = unit_last_ack_q[4*gi +: 4];
				if (unit_ack[gi].pkt_start) begin
					cnt_d = 4'h0;
				end else if (unit_ack[gi].ack_valid && unit_ack[gi].ack_retryable) begin
					if (cnt_q < limit) begin
						retry_d = 1'b1;
						cnt_d   = cnt_q + 4'h1;
					end else begin
						give_up_d = 1'b1;
						last_d    = unit_ack[gi].ack_code;
					end
				end
			end

			// Outputs are one-cycle pulses except the held last ack
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cnt_q                      <= 4'h0;
					unit_retry_q[gi]           <= 1'b0;
					unit_give_up_q[gi]         <= 1'b0;
					unit_last_ack_q[4*gi +: 4] <= 4'h0;
				end else begin
					cnt_q                      <= cnt_d;
					unit_retry_q[gi]           <= retry_d;
					unit_give_up_q[gi]         <= give_up_d;
					unit_last_ack_q[4*gi +: 4] <= last_d;
				end
			end

			chk_retry_zero_limit: assert property (@(posedge clk) disable iff (rst)
				(unit_ack[gi].ack_valid && unit_ack[gi].ack_retryable && !unit_ack[gi].pkt_start && limit == 4'h0)
				|=> (unit_give_up_q[gi] && !unit_retry_q[gi]))
				else $error("zero retry limit did not give up");
			chk_retry_bound: assert property (@(posedge clk) disable iff (rst)
				unit_retry_q[gi] |-> (cnt_q <= limit))
				else $error("retry count passed its limit");

			// Per-unit pulses: retry while count remains, then give up on each further retryable ack
			chk_retry_pulse: assert property (@(posedge clk) disable iff (rst)
				(unit_ack[gi].ack_valid && unit_ack[gi].ack_retryable && !unit_ack[gi].pkt_start && cnt_q < limit)
				|=> (unit_retry_q[gi] && !unit_give_up_q[gi]))
				else $error("busy ack with retries left was not retried");
			chk_give_up_code: assert property (@(posedge clk) disable iff (rst)
				(unit_ack[gi].ack_valid && unit_ack[gi].ack_retryable && !unit_ack[gi].pkt_start && cnt_q >= limit)
				|=> (unit_give_up_q[gi] && unit_last_ack_q[4*gi +: 4] == $past(unit_ack[gi].ack_code)))
				else $error("give up did not keep the last ack");
			chk_pkt_start_quiet: assert property (@(posedge clk) disable iff (rst)
				unit_ack[gi].pkt_start |=> (!unit_retry_q[gi] && !unit_give_up_q[gi]))
				else $error("packet start raised a retry pulse");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Checks

	chk_version_read: assert property (@(posedge clk) disable iff (rst)
		(rd_en && addr == `VRAR_OFF_VERSION)
		|=> (rd_data_q[31:25] == 7'h00 && rd_data_q[23:0] == 24'h010000))
		else $error("version word wrong");
	chk_present_flag: assert property (@(posedge clk) disable iff (rst)
		(rd_en && addr == `VRAR_OFF_VERSION) |=> (rd_data_q[24] == $past(rom_detect, 2)))
		else $error("presence flag does not follow detect");
	chk_rom_reserved: assert property (@(posedge clk) disable iff (rst)
		(rd_en && addr == `VRAR_OFF_ROM_ACCESS)
		|=> (rd_data_q[30:26] == 5'h00 && !rd_data_q[24] && rd_data_q[15:0] == 16'h0000))
		else $error("access register reserved bits set");
	chk_retry_reserved: assert property (@(posedge clk) disable iff (rst)
		(rd_en && addr == `VRAR_OFF_RETRY) |=> (rd_data_q[31:12] == 20'h00000))
		else $error("retry register upper bits set");

	// ROM engine: address clear, byte read and boot load
	chk_clear_done: assert property (@(posedge clk) disable iff (rst)
		(state_q == vrar_pkg::VRAR_ST_IDLE && !boot_pend_q && addr_clear_q && !wr_rom)
		|=> (!addr_clear_q && rom_addr_q == '0 && $stable(read_byte_q)))
		else $error("address clear not finished cleanly");
	chk_clear_wait: assert property (@(posedge clk) disable iff (rst)
		(state_q != vrar_pkg::VRAR_ST_IDLE && addr_clear_q) |=> addr_clear_q)
		else $error("address clear dropped while the engine was busy");
	chk_go_done: assert property (@(posedge clk) disable iff (rst)
		(state_q == vrar_pkg::VRAR_ST_FETCH && rom_done && !wr_rom)
		|=> (!read_go_q && read_byte_q == $past(rom_data) && !rom_req_q))
		else $error("byte read did not complete");
	chk_go_start: assert property (@(posedge clk) disable iff (rst)
		(state_q == vrar_pkg::VRAR_ST_IDLE && !boot_pend_q && !addr_clear_q && read_go_q)
		|=> (state_q == vrar_pkg::VRAR_ST_FETCH && rom_req_q))
		else $error("byte read did not start");
	// Zero write must not cancel a read, even one already out on the ROM link
	chk_write_zero: assert property (@(posedge clk) disable iff (rst)
		(wr_rom && wr_data[`VRAR_ROM_GO_BIT] == 1'b0 && read_go_q && !dev_clear_go)
		|=> read_go_q)
		else $error("writing zero cleared the read bit");
	chk_boot_start: assert property (@(posedge clk) disable iff (rst)
		(boot_pend_q && rom_detect) |=> (state_q == vrar_pkg::VRAR_ST_LOAD && rom_req_q && rom_addr_q == '0))
		else $error("boot load did not start");
	chk_boot_fill: assert property (@(posedge clk) disable iff (rst)
		(state_q == vrar_pkg::VRAR_ST_LOAD && rom_done && load_idx_q == 8'(INFO_BYTES - 1))
		|=> (bus_info_valid_q && !rom_req_q && rom_addr_q == '0))
		else $error("boot load did not finish");
	// Address must hold while the ROM side is still working on it
	chk_addr_hold: assert property (@(posedge clk) disable iff (rst)
		(rom_req_q && !rom_done) |=> $stable(rom_addr_q))
		else $error("ROM address moved during a request");

	// Retry limit fields are plain read/write storage
	chk_retry_write: assert property (@(posedge clk) disable iff (rst)
		wr_retry |=> (32'(limits_q) == ($past(wr_data) & 32'h0000_0fff)))
		else $error("retry limits did not take the write");

endmodule : vrar_regs
`default_nettype wire

// ==== include/vrar_defines.svh ====
// Offsets, field positions, reset values and constants of the version, ROM access and retry registers
// Notes on behaviour
// - Version register bits 31-25 and 15-8 always read as zero.
// - Version bit 24 shows whether a serial ROM is attached.
// - With a ROM present, bus information bytes load by themselves after reset.
// - Version bits 23-16 read the major version 01h.
// - Version bits 7-0 read the minor version 00h.
// - Bit 31 returns the ROM byte address to zero; device clears it after.
// - An address clear leaves the read byte field untouched.
// - Bit 25 starts a byte read; device clears it when the byte arrives.
// - The fetched ROM byte is shown in bits 23-16 of the access register.
// - Access register bits 30-26, 24 and 15-0 always read as zero.
// - Retry register bits 31-16 read zero; dual-phase retry is absent.
// - Physical response unit retries up to the count in bits 11-8.
// - Transmit response unit retries up to the count in bits 7-4.
// - Transmit request unit retries up to the count in bits 3-0.
// - Retry bits 15-12 read zero; the three count fields are read/write.
`ifndef VRAR_DEFINES_SVH
`define VRAR_DEFINES_SVH

`define VRAR_OFF_VERSION     8'h00
`define VRAR_OFF_ROM_ACCESS  8'h04
`define VRAR_OFF_RETRY       8'h08

`define VRAR_VER_PRESENT_BIT 24
`define VRAR_VER_MAJOR       8'h01
`define VRAR_VER_MINOR       8'h00

`define VRAR_ROM_CLEAR_BIT   31
`define VRAR_ROM_GO_BIT      25
`define VRAR_ROM_BYTE_LSB    16

`define VRAR_RETRY_LIMITS_W  12
`define VRAR_RETRY_RESET     12'h000
`define VRAR_ROM_BYTE_RESET  8'h00

`define VRAR_BUS_INFO_BYTES  16

`endif

// ==== include/vrar_pkg.sv ====
// Types shared by the version, ROM access and retry register block
`default_nettype none
package vrar_pkg;

	// Acknowledge report from one transmit unit
	typedef struct packed {
		logic       pkt_start;
		logic       ack_valid;
		logic       ack_retryable;
		logic [3:0] ack_code;
	} vrar_ack_t;

	// Retry limits as software sees them, high field first in descending index order
	typedef struct packed {
		logic [3:0] phys_resp_retry_limit;
		logic [3:0] async_resp_retry_limit;
		logic [3:0] async_req_retry_limit;
	} vrar_limits_t;

	// ROM engine states
	typedef enum logic [1:0] {
		VRAR_ST_IDLE  = 2'b00,
		VRAR_ST_LOAD  = 2'b01,
		VRAR_ST_FETCH = 2'b10
	} vrar_state_t;

endpackage : vrar_pkg
`default_nettype wire

// ==== testbench/vrar_rom_model.sv ====
// Behavioural serial ROM that answers byte requests after a set latency
`timescale 1ns/100ps
`default_nettype none
module vrar_rom_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       req,
	input  wire logic [7:0] addr,
	input  wire logic [3:0] lat,
	output logic            done,
	output logic      [7:0] data
);
	logic [3:0] cnt_q;

	// Byte valid only with done; it toggles otherwise, so stale data never looks good
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
			done  <= 1'b0;
			data  <= 8'h00;
		end else if (req && !done && cnt_q >= lat) begin
			cnt_q <= 4'h0;
			done  <= 1'b1;
			data  <= addr ^ 8'h5a;
		end else begin
			cnt_q <= (req && !done) ? cnt_q + 4'h1 : 4'h0;
			done  <= 1'b0;
			data  <= ~data;
		end
	end
endmodule : vrar_rom_model
`default_nettype wire

// ==== testbench/vrar_regs_tb.sv ====
// Self-checking bench for the version, ROM access and retry register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h want %h", $time, a, e); end end
module vrar_regs_tb;
	logic                      clk = 1'b0;
	logic                      rst = 1'b1;
	logic [7:0]                addr = 8'h00;
	logic [31:0]               wr_data = 32'h0, rd_data_q, rd_v, wv;
	logic                      wr_en = 1'b0, rd_en = 1'b0, rom_detect = 1'b1, rom_req_q, rom_done;
	logic [7:0]                rom_addr_q, rom_data;
	logic [127:0]              bus_info_q;
	logic                      bus_info_valid_q;
	vrar_pkg::vrar_ack_t [2:0] unit_ack = '0;
	logic [2:0]                unit_retry_q, unit_give_up_q;
	logic [11:0]               unit_last_ack_q;
	logic [3:0]                lat = 4'h2, code;
	int                        n_mismatch = 0, samples_checked = 0, n;

	vrar_regs i_vrar_regs (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data_q(rd_data_q), .rom_detect(rom_detect), .rom_req_q(rom_req_q), .rom_addr_q(rom_addr_q),
		.rom_done(rom_done), .rom_data(rom_data), .bus_info_q(bus_info_q), .bus_info_valid_q(bus_info_valid_q),
		.unit_ack(unit_ack), .unit_retry_q(unit_retry_q), .unit_give_up_q(unit_give_up_q),
		.unit_last_ack_q(unit_last_ack_q));
	vrar_rom_model i_vrar_rom_model (.clk(clk), .rst(rst), .req(rom_req_q), .addr(rom_addr_q), .lat(lat),
		.done(rom_done), .data(rom_data));

	// 20 MHz clock
	always #25 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// Expected ROM contents, same pattern the model serves
	function automatic logic [7:0] exp_byte(input logic [7:0] a);
		return a ^ 8'h5a;
	endfunction : exp_byte

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	// One-cycle read strobe; data taken in the following cycle only
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data_q;
	endtask : rd

	// Start a byte read and poll until the device drops the go bit
	task automatic fetch(input logic [7:0] b);
		wr(8'h04, 32'h02000000);
		rd_v = 32'h02000000;
		for (int k = 0; k < 40 && rd_v[25]; k++) rd(8'h04, rd_v);
		`CHK(rd_v, {8'h00, b, 16'h0000})
	endtask : fetch

	// One ack cycle on a unit, then pulses checked in the next cycle
	task automatic ack(input int u, input logic s, input logic r, input logic [2:0] rt, input logic [2:0] gu);
		@(posedge clk);
		unit_ack[u] <= '{s, !s, r, code};
		@(posedge clk);
		unit_ack[u] <= '0;
		#1;
		`CHK(unit_retry_q, rt)
		`CHK(unit_give_up_q, gu)
	endtask : ack

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////
	// Watchdog: whole run is a few hundred cycles, so five thousand means a hang
	initial begin
		#(5000 * 50);
		n_mismatch++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		void'($urandom(34));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < 300 && !bus_info_valid_q; k++) @(posedge clk);
		`CHK(bus_info_valid_q, 1'b1)
		for (int k = 0; k < 16; k++) `CHK(bus_info_q[8*k +: 8], exp_byte(8'(k)))
		rd(8'h00, rd_v);
		`CHK(rd_v, 32'h01010000)
		wr(8'h00, $urandom);
		rom_detect <= 1'b0;
		rd(8'h00, rd_v);
		`CHK(rd_v, 32'h00010000)
		rom_detect <= 1'b1;
		rd(8'h0c, rd_v);
		`CHK(rd_v, 32'h00000000)
		$display("test version done");
		// Retry limits: all-ones corner first, then random words
		for (int k = 0; k < 8; k++) begin
			wv = (k == 0) ? 32'hffffffff : $urandom;
			n = int'(wv[11:0]);
			wr(8'h08, wv);
			rd(8'h08, rd_v);
			`CHK(rd_v, {20'h00000, 12'(n)})
		end
		$display("test retry register done");
		// Address clear, then reads at random ROM latency
		wr(8'h04, 32'h80000000);
		rd(8'h04, rd_v);
		`CHK(rd_v, 32'h00000000)
		for (int k = 0; k < 5; k++) begin
			lat <= 4'($urandom_range(0, 6));
			fetch(exp_byte(8'(k)));
		end
		// Slow ROM: writing zero must not cancel a pending read
		lat <= 4'hf;
		wr(8'h04, 32'h02000000);
		wr(8'h04, 32'h00000000);
		rd(8'h04, rd_v);
		`CHK(rd_v, {8'h02, exp_byte(8'h04), 16'h0000})
		fetch(exp_byte(8'h05));
		wr(8'h04, 32'h80000000);
		rd(8'h04, rd_v);
		`CHK(rd_v, {8'h00, exp_byte(8'h05), 16'h0000})
		lat <= 4'h0;
		fetch(exp_byte(8'h00));
		$display("test rom access done");
		// Each transmit unit: n retries, then give up and keep the last ack code
		for (int u = 0; u < 3; u++) begin
			n = (u == 1) ? 0 : $urandom_range(1, 3); // Unit 1 takes the zero-limit corner
			code = 4'($urandom);
			wr(8'h08, 32'(n) << (4 * u));
			ack(u, 1'b1, 1'b0, 3'h0, 3'h0);
			repeat (n) ack(u, 1'b0, 1'b1, 3'(1 << u), 3'h0);
			ack(u, 1'b0, 1'b1, 3'h0, 3'(1 << u));
			`CHK(unit_last_ack_q[4*u +: 4], code)
			ack(u, 1'b0, 1'b0, 3'h0, 3'h0);
		end
		$display("test retry units done");
		report_and_stop();
	end
endmodule : vrar_regs_tb
`default_nettype wire
